// >>> hw/tsm_pkg.sv
// Purpose: Shared constants for the temperature monitor serial slave port.
// Assumes: 8-bit registers, separate read and write pointer codes.
// Notes: Strap pins arrive as two-bit level codes from the pad detector.

package tsm_pkg;

  // ****************************************
  // Register pointer codes
  // ****************************************
  localparam logic [7:0] TSM_RD_REMOTE = 8'h01;
  localparam logic [7:0] TSM_RD_CONFIG = 8'h03;
  localparam logic [7:0] TSM_WR_CONFIG = 8'h09;
  localparam logic [7:0] TSM_WR_ONESHOT = 8'h0F;
  localparam logic [7:0] TSM_RD_CORR = 8'h11;
  localparam logic [7:0] TSM_WR_CORR = 8'h11;

  // ****************************************
  // Fields and values after reset
  // ****************************************
  localparam int TSM_CFG_STANDBY_BIT = 6;
  localparam int TSM_CFG_MASK_BIT = 7;
  localparam logic [7:0] TSM_CFG_USED = 8'hC0;
  localparam logic [7:0] TSM_CFG_RESET = 8'h00;
  localparam logic [7:0] TSM_CORR_RESET = 8'h00;
  localparam logic [7:0] TSM_REMOTE_RESET = 8'h80;
  localparam logic [7:0] TSM_READ_UNMAPPED = 8'h00;

  // ****************************************
  // Strap decode
  // ****************************************
  localparam logic [1:0] TSM_STRAP_LOW = 2'h0;
  localparam logic [1:0] TSM_STRAP_OPEN = 2'h1;
  localparam logic [3:0] TSM_NIB_LOW = 4'h3;
  localparam logic [3:0] TSM_NIB_OPEN = 4'h5;
  localparam logic [3:0] TSM_NIB_HIGH = 4'h9;
  localparam logic [2:0] TSM_BASE_LOW = 3'h0;
  localparam logic [2:0] TSM_BASE_OPEN = 3'h1;
  localparam logic [2:0] TSM_BASE_HIGH = 3'h4;
  // Cycles after reset release before the straps are caught
  localparam logic [1:0] TSM_STRAP_SETTLE = 2'h3;

  // ****************************************
  // Serial framing counts
  // ****************************************
  localparam logic [3:0] TSM_BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] TSM_MAX_WRITE_BYTES = 2'h2;

  typedef enum logic [2:0] {
    TSM_ST_IDLE = 3'b000,
    TSM_ST_ADDR = 3'b001,
    TSM_ST_ACK = 3'b011,
    TSM_ST_WDATA = 3'b010,
    TSM_ST_RDATA = 3'b110,
    TSM_ST_RACK = 3'b111
  } tsm_state_e;

  // Strap pair to 7-bit bus address: nibble from the first, low bits summed
  function automatic logic [6:0] tsm_dev_addr(input logic [1:0] first, input logic [1:0] second);
    logic [3:0] nib;
    logic [2:0] base;
    logic [2:0] idx;
    nib = TSM_NIB_HIGH;
    base = TSM_BASE_HIGH;
    if (first == TSM_STRAP_LOW) begin
      nib = TSM_NIB_LOW;
      base = TSM_BASE_LOW;
    end else if (first == TSM_STRAP_OPEN) begin
      nib = TSM_NIB_OPEN;
      base = TSM_BASE_OPEN;
    end
    idx = (second == TSM_STRAP_LOW) ? 3'h0 : (second == TSM_STRAP_OPEN) ? 3'h1 : 3'h2;
    return {nib, 3'(base + idx)};
  endfunction

endpackage

// >>> hw/tsm_sync.sv
// Purpose: Two-stage synchroniser for pin levels entering the ref_clk domain.
// Assumes: Inputs are levels; pulses shorter than one clock may be lost.
// Notes: Only the second stage is visible outside.

`timescale 1ns/100ps

module tsm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Level in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds the second stage only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// >>> hw/tsm_slave.sv
// Behaviour
// - Correction byte lives at pointer 0x11, readable and writable.
// - Correction byte is signed; set top bit means negative.
// - Correction is added to each remote reading before it is stored.
// - Correction clears to zero at reset.
// - In standby a trigger write runs one conversion, then standby resumes.
// - Trigger write starts conversion; its data byte is dropped.
// - Write code 0x0F triggers only under config standby with pin high.
// - Low standby pin blocks every conversion, triggered ones too.
// - Bus address comes from two three-level straps, nine choices.
// - First strap picks upper nibble; both straps set the low bits.
// - Straps are caught once after reset and never again.
// - Start is data falling with clock high; address then direction follow.
// - On match, pull data low for the ninth clock; else stay idle.
// - Direction 0 is master write, 1 is master read.
// - Nine clocks per byte; device acknowledges bytes the master writes.
// - Data rising with clock high is a stop.
// - Direction is fixed by the address byte until a new start.
// - Writes carry one or two bytes; reads return one byte.
// - First written byte always loads the register pointer.
// - Second written byte goes to the register the pointer selects.
// - Read returns the register selected by the current pointer.
// - Read and write pointer codes are separate register maps.
// - Read pointer 0x01 returns the corrected remote result.
//
// Purpose: Serial slave port, pointer, correction, config and one-shot control.
// Assumes: Serial clock under a fifth of ref_clk; straps come as level codes.
// Notes: Data line is open drain: out is always low, oe pulls it down.

`timescale 1ns/100ps

module tsm_slave (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Serial bus pins
  input wire logic serial_clock_line,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  // Straps and standby pin
  input wire logic [1:0] address_strap_first,
  input wire logic [1:0] address_strap_second,
  input wire logic standby_pin_n,
  // Converter side
  input wire logic [7:0] remote_raw,
  input wire logic remote_raw_valid,
  output logic conversion_run,
  output logic conversion_start,
  output logic alert_masked,
  output logic [7:0] remote_result,
  output logic [6:0] device_address
);
  import tsm_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic scl_s, sda_s, standby_pin_n_s;
  logic [1:0] strap0_s, strap1_s;
  logic scl_d, sda_d;

  tsm_sync #(.WIDTH(7), .RESET_VAL(7'h60)) u_sync ( // Bus pins idle high: no false edge
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({serial_clock_line, serial_data_line_in, standby_pin_n,
               address_strap_first, address_strap_second}),
    .sync_out({scl_s, sda_s, standby_pin_n_s, strap0_s, strap1_s})
  );

  // Delayed copies for edge detection
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************
  // Strap capture
  // ****************************************
  logic [1:0] settle_cnt;
  logic strap_taken;

  // Caught once after reset; later strap changes are never looked at
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt <= 2'h0;
      strap_taken <= 1'b0;
      device_address <= 7'h00;
    end else if (!strap_taken) begin
      settle_cnt <= settle_cnt + 2'h1;
      if (settle_cnt == TSM_STRAP_SETTLE) begin
        strap_taken <= 1'b1;
        device_address <= tsm_dev_addr(strap0_s, strap1_s);
      end
    end
  end

  // ****************************************
  // Serial state machine
  // ****************************************
  tsm_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] rd_shift;
  logic [1:0] byte_idx;
  logic dir_read;
  logic [7:0] pointer;
  logic wr_strobe;
  logic [7:0] wr_data;
  logic [7:0] rd_value;
  logic addr_match;
  logic [7:0] cfg;
  logic [7:0] correction;

  assign addr_match = strap_taken && (shift_in[7:1] == device_address);

  // Read mux; any code outside the read map gives zero
  always_comb begin
    unique case (pointer)
      TSM_RD_REMOTE: rd_value = remote_result;
      TSM_RD_CONFIG: rd_value = cfg & TSM_CFG_USED;
      TSM_RD_CORR: rd_value = correction;
      default: rd_value = TSM_READ_UNMAPPED;
    endcase
  end

  // Start and stop win over clock edges, so a new start always resyncs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= TSM_ST_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      rd_shift <= 8'h00;
      byte_idx <= 2'h0;
      dir_read <= 1'b0;
      pointer <= 8'h00;
      wr_strobe <= 1'b0;
      wr_data <= 8'h00;
      serial_data_line_oe <= 1'b0;
      serial_data_line_out <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      if (start_seen) begin
        state <= TSM_ST_ADDR;
        bit_cnt <= 4'h0;
        byte_idx <= 2'h0;
        serial_data_line_oe <= 1'b0;
      end else if (stop_seen) begin
        state <= TSM_ST_IDLE;
        serial_data_line_oe <= 1'b0;
      end else begin
        unique case (state)
          TSM_ST_IDLE: begin
            serial_data_line_oe <= 1'b0;
          end
          TSM_ST_ADDR, TSM_ST_WDATA: begin
            if (scl_rise) begin
              shift_in <= {shift_in[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == TSM_BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              if (state == TSM_ST_ADDR) begin
                if (addr_match) begin
                  serial_data_line_oe <= 1'b1;
                  dir_read <= shift_in[0];
                  state <= TSM_ST_ACK;
                end else begin
                  state <= TSM_ST_IDLE;
                end
              end else if (byte_idx == 2'h0) begin
                pointer <= shift_in;
                byte_idx <= 2'h1;
                serial_data_line_oe <= 1'b1;
                state <= TSM_ST_ACK;
              end else if (byte_idx == 2'h1) begin
                wr_strobe <= 1'b1;
                wr_data <= shift_in;
                byte_idx <= TSM_MAX_WRITE_BYTES;
                serial_data_line_oe <= 1'b1;
                state <= TSM_ST_ACK;
              end else begin
                state <= TSM_ST_IDLE;
              end
            end
          end
          TSM_ST_ACK: begin
            if (scl_fall) begin
              if (dir_read) begin
                rd_shift <= rd_value;
                serial_data_line_oe <= ~rd_value[7];
                state <= TSM_ST_RDATA;
              end else begin
                serial_data_line_oe <= 1'b0;
                state <= TSM_ST_WDATA;
              end
            end
          end
          TSM_ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == TSM_BITS_PER_BYTE) begin
                serial_data_line_oe <= 1'b0;
                state <= TSM_ST_RACK;
              end else begin
                rd_shift <= {rd_shift[6:0], 1'b0};
                serial_data_line_oe <= ~rd_shift[6];
              end
            end
          end
          TSM_ST_RACK: begin
            if (scl_rise) begin
              state <= TSM_ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************
  // Only write codes reach storage; the trigger code stores nothing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      correction <= TSM_CORR_RESET;
      cfg <= TSM_CFG_RESET;
    end else if (wr_strobe) begin
      if (pointer == TSM_WR_CORR) begin
        correction <= wr_data;
      end else if (pointer == TSM_WR_CONFIG) begin
        cfg <= wr_data & TSM_CFG_USED;
      end
    end
  end

  // ****************************************
  // Conversion control and result
  // ****************************************
  logic oneshot_req, oneshot_busy, result_take;
  logic signed [8:0] corr_sum;
  logic [7:0] corr_sat;

  assign oneshot_req = wr_strobe && pointer == TSM_WR_ONESHOT;
  assign result_take = remote_raw_valid && standby_pin_n_s &&
                       (!cfg[TSM_CFG_STANDBY_BIT] || oneshot_busy);
  // Saturate rather than wrap so a hot reading never reads back cold
  assign corr_sum = $signed({remote_raw[7], remote_raw}) +
                    $signed({correction[7], correction});
  assign corr_sat = (corr_sum > 9'sd127) ? 8'h7F :
                    (corr_sum < -9'sd128) ? 8'h80 : corr_sum[7:0];

  // Trigger honoured only in config standby with the pin high
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      conversion_start <= 1'b0;
      oneshot_busy <= 1'b0;
      conversion_run <= 1'b0;
      alert_masked <= 1'b0;
    end else begin
      conversion_start <= oneshot_req && cfg[TSM_CFG_STANDBY_BIT] && standby_pin_n_s;
      conversion_run <= !cfg[TSM_CFG_STANDBY_BIT] && standby_pin_n_s;
      alert_masked <= cfg[TSM_CFG_MASK_BIT];
      // Set wins over clear so a back-to-back trigger is not lost
      if (conversion_start) begin
        oneshot_busy <= 1'b1;
      end else if (result_take || !standby_pin_n_s) begin
        oneshot_busy <= 1'b0;
      end
    end
  end

  // Corrected result store
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      remote_result <= TSM_REMOTE_RESET;
    end else if (result_take) begin
      remote_result <= corr_sat;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_oneshot_write;
    wr_strobe && pointer == TSM_WR_ONESHOT;
  endsequence

  sequence s_addr_ack;
    state == TSM_ST_ADDR && scl_fall && bit_cnt == TSM_BITS_PER_BYTE && addr_match;
  endsequence

  a_corr_reset: assert property (@(posedge ref_clk) $rose(reset_n) |-> correction == 8'h00)
    else $error("correction not zero after reset");
  a_corr_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_strobe && pointer == 8'h11 |=> correction == $past(wr_data))
    else $error("correction write lost");
  a_result_plain: assert property (@(posedge ref_clk) disable iff (!reset_n)
    result_take && correction == 8'h00 |=> remote_result == $past(remote_raw))
    else $error("zero correction altered result");
  a_result_sign: assert property (@(posedge ref_clk) disable iff (!reset_n)
    result_take && correction[7] |=> $signed(remote_result) <= $signed($past(remote_raw)))
    else $error("negative correction raised result");
  a_oneshot_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_oneshot_write ##0 (cfg[6] && standby_pin_n_s) |=> conversion_start)
    else $error("trigger did not start conversion");
  a_oneshot_nostore: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_oneshot_write |=> $stable(correction) && $stable(cfg))
    else $error("trigger data was stored");
  a_standby_block: assert property (@(posedge ref_clk) disable iff (!reset_n)
    conversion_start || conversion_run |-> $past(standby_pin_n_s))
    else $error("conversion while standby pin low");
  a_ack_drive: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_addr_ack |=> serial_data_line_oe && state == TSM_ST_ACK)
    else $error("address match not acknowledged");
  a_line_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    serial_data_line_oe |-> state inside {TSM_ST_ACK, TSM_ST_RDATA})
    else $error("data line driven outside ack or read");
  a_stop_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    stop_seen |=> state == TSM_ST_IDLE && !serial_data_line_oe)
    else $error("stop not honoured");
  a_strap_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    strap_taken && $past(strap_taken) |-> $stable(device_address))
    else $error("address changed after capture");
  a_pointer_load: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == TSM_ST_WDATA && scl_fall && bit_cnt == 4'h8 && byte_idx == 2'h0
    |=> pointer == $past(shift_in))
    else $error("first write byte not in pointer");

endmodule

// >>> tb/tsm_master.sv
// Purpose: Behavioural serial bus master that drives the slave port's bus pins.
// Assumes: Data line has a pull-up; this model only pulls it low or lets go.
// Notes: Bus clock period is eight ref_clk cycles and stands high between frames.

`timescale 1ns/100ps

module tsm_master (
  // Clock used only to pace the bus
  input wire logic ref_clk,
  // Resolved data line level
  input wire logic sda,
  // Driven bus pins
  output logic scl,
  output logic sda_low
);
  // ****************************************
  // Pacing and bit level
  // ****************************************
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Step off the edge so the slave never races our changes
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Data moves only in the clock-low half, sampled late in the high half
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    wait_clk(1);
    sda_low = ~b;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(4);
    r = sda;
  endtask

  // ****************************************
  // Framing
  // ****************************************
  // Data falls while the clock is high
  task automatic start_cond();
    sda_low = 1'b0;
    wait_clk(2);
    sda_low = 1'b1;
    wait_clk(4);
  endtask

  // Data low in the clock-low half, then rises while clock is high
  task automatic stop_cond();
    scl = 1'b0;
    wait_clk(1);
    sda_low = 1'b1;
    wait_clk(3);
    scl = 1'b1;
    wait_clk(4);
    sda_low = 1'b0;
    wait_clk(8);
  endtask

  // Eight bits MSB first, ninth clock carries the slave's answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // One byte in, then no-acknowledge since reads are one byte long
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r);
  endtask
endmodule

// >>> tb/smbus_slave_register_port_tb.sv
// Purpose: Self-checking bench for the temperature monitor serial slave port.
// Assumes: Straps open/high at reset, giving bus address 0101 011.
// Notes: Expected values are worked out here, never read back from the design.

`timescale 1ns/100ps

module smbus_slave_register_port_tb;
  import tsm_pkg::*;

  // ****************************************
  // Signals and instances
  // ****************************************
  logic ref_clk, reset_n, scl, m_low, oe, out, standby_pin_n, remote_raw_valid;
  logic conversion_run, conversion_start, alert_masked;
  logic [1:0] strap_a, strap_b;
  logic [7:0] remote_raw, remote_result;
  logic [6:0] device_address;
  wire logic sda;
  int bad_count = 0;
  int cmp_count = 0;
  int starts = 0;
  localparam logic [6:0] DEV = 7'h2B;

  // Open-drain wire with pull-up: low if either party pulls
  assign sda = (m_low || (oe && !out)) ? 1'b0 : 1'b1;

  tsm_master M (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(m_low));

  tsm_slave DUT (.ref_clk(ref_clk), .reset_n(reset_n), .serial_clock_line(scl),
    .serial_data_line_in(sda), .serial_data_line_out(out), .serial_data_line_oe(oe),
    .address_strap_first(strap_a), .address_strap_second(strap_b),
    .standby_pin_n(standby_pin_n), .remote_raw(remote_raw),
    .remote_raw_valid(remote_raw_valid), .conversion_run(conversion_run),
    .conversion_start(conversion_start), .alert_masked(alert_masked),
    .remote_result(remote_result), .device_address(device_address));

  // Count single-conversion pulses; a one-cycle pulse is easy to miss by polling
  always @(posedge ref_clk) begin
    if (conversion_start === 1'b1) starts++;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Write of pointer and, if two, a data byte; every byte must be acked
  task automatic do_write(input logic [7:0] ptr, input logic [7:0] dat, input bit two);
    logic a;
    M.start_cond();
    M.wbyte({DEV, 1'b0}, a);
    chk(a, 1, "addr ack");
    M.wbyte(ptr, a);
    chk(a, 1, "ptr ack");
    if (two) begin
      M.wbyte(dat, a);
      chk(a, 1, "data ack");
    end
    M.stop_cond();
  endtask

  // Pointer-only write, then a separate one-byte read
  task automatic do_read(input logic [7:0] ptr, input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    do_write(ptr, 8'h00, 0);
    M.start_cond();
    M.wbyte({DEV, 1'b1}, a);
    chk(a, 1, "read ack");
    M.rbyte(d);
    M.stop_cond();
    chk(d, exp, "read data");
  endtask

  // One converter result pulse
  task automatic conv(input logic [7:0] raw);
    @(posedge ref_clk);
    #1;
    remote_raw = raw;
    remote_raw_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    remote_raw_valid = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_addr();
    chk({1'b0, device_address}, {1'b0, DEV}, "address");
    chk(remote_result, 8'h80, "result reset");
    chk(out, 0, "drain level");
    strap_a = TSM_STRAP_LOW;
    strap_b = TSM_STRAP_LOW;
    repeat (10) @(posedge ref_clk);
    chk({1'b0, device_address}, {1'b0, DEV}, "address held");
    $display("test addr done");
  endtask

  task automatic t_corr();
    do_read(8'h11, 8'h00);
    do_write(8'h11, 8'hFC, 1);
    do_read(8'h11, 8'hFC);
    conv(8'h12);
    chk(remote_result, 8'h0E, "negative corr");
    do_read(8'h01, 8'h0E);
    do_write(8'h11, 8'h00, 1);
    conv(8'h12);
    chk(remote_result, 8'h12, "zero corr");
    do_write(8'h11, 8'h04, 1);
    conv(8'h12);
    chk(remote_result, 8'h16, "positive corr");
    $display("test correction done");
  endtask

  task automatic t_map();
    do_write(8'h20, 8'h55, 1);
    do_read(8'h20, 8'h00);
    do_write(8'h09, 8'h80, 1);
    do_read(8'h09, 8'h00);
    do_read(8'h03, 8'h80);
    chk(alert_masked, 1, "mask bit");
    do_write(8'h09, 8'h00, 1);
    $display("test map done");
  endtask

  task automatic t_refuse();
    logic a;
    M.start_cond();
    M.wbyte({7'h2C, 1'b0}, a);
    M.stop_cond();
    chk(a, 0, "foreign addr");
    M.start_cond();
    M.wbyte({DEV, 1'b0}, a);
    M.wbyte(8'h11, a);
    M.wbyte(8'h04, a);
    M.wbyte(8'h33, a);
    M.stop_cond();
    chk(a, 0, "third byte");
    do_read(8'h11, 8'h04);
    $display("test refuse done");
  endtask

  task automatic t_oneshot();
    int base;
    do_write(8'h09, 8'h40, 1);
    chk(conversion_run, 0, "standby");
    conv(8'h50);
    chk(remote_result, 8'h16, "no run in standby");
    base = starts;
    do_write(8'h0F, 8'hAA, 1);
    chk(8'(starts - base), 1, "trigger");
    conv(8'h20);
    chk(remote_result, 8'h24, "one result");
    conv(8'h30);
    chk(remote_result, 8'h24, "back to standby");
    do_read(8'h0F, 8'h00);
    standby_pin_n = 1'b0;
    repeat (5) @(posedge ref_clk);
    do_write(8'h0F, 8'h01, 1);
    chk(8'(starts - base), 1, "pin blocks");
    conv(8'h40);
    chk(remote_result, 8'h24, "pin blocks result");
    standby_pin_n = 1'b1;
    do_write(8'h09, 8'h00, 1);
    repeat (5) @(posedge ref_clk);
    chk(conversion_run, 1, "run again");
    $display("test oneshot done");
  endtask

  // ****************************************
  // Verdict, clock, watchdog, main sequence
  // ****************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Tests take about 5500 cycles; 20000 cycles leaves ample margin
  initial begin
    #400000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    reset_n = 1'b0;
    strap_a = TSM_STRAP_OPEN;
    strap_b = 2'h2;
    standby_pin_n = 1'b1;
    remote_raw = 8'h00;
    remote_raw_valid = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    repeat (20) @(posedge ref_clk);
    #1;
    t_addr();
    t_corr();
    t_map();
    t_refuse();
    t_oneshot();
    print_verdict();
  end
endmodule
